// file: uart_cfg.svh
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// register byte addresses on the bus
`define ADDR_DATA        8'h00
`define ADDR_DIV_HIGH    8'h04
`define ADDR_DIV_LOW     8'h08
`define ADDR_FIFO_MOD    8'h0c
`define ADDR_FILL_COUNT  8'h10
`define ADDR_CONTROL     8'h14
`define ADDR_STATUS      8'h18

// fifo_and_modulation_control fields
`define FMC_TRIG_LSB     0
`define FMC_TRIG_MSB     1
`define FMC_RANGE_BIT    2
`define FMC_MOD_LSB      3
`define FMC_MOD_MSB      5

// control fields
`define CTL_ENABLE_BIT   0
`define CTL_RXIE_BIT     1

// status fields
`define STS_RXAVAIL_BIT  0
`define STS_OVERRUN_BIT  1
`define STS_TXEMPTY_BIT  2

// reset values
`define DIV_BYTE_RESET   8'h00
`define FMC_RESET        8'h00

// frame layout
`define DATA_BITS        4'h8
`define TX_FRAME_BITS    4'hb
`define MOD_CARRY_LIMIT  4'h8

// bus answers
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// file: uart_pkg.sv
package uart_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;
endpackage

// file: uart_baud_gen_rx_fifo.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "uart_cfg.svh"

module uart_baud_gen_rx_fifo #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             port_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        aw_full_reg, aw_full_next;
  logic [7:0]  w_data_reg, w_data_next;
  logic        w_lane_reg, w_lane_next;
  logic        w_full_reg, w_full_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  div_high_reg, div_high_next;
  logic [7:0]  div_low_reg, div_low_next;
  logic [2:0]  mod_reg, mod_next;
  logic        range_reg, range_next;
  logic [1:0]  trig_reg, trig_next;
  logic        enable_reg, enable_next;
  logic        rxie_reg, rxie_next;
  logic        overrun_reg, overrun_next;
  logic        tx_pend_reg, tx_pend_next;
  logic [7:0]  tx_buf_reg, tx_buf_next;

  logic        do_write, do_read, pop;
  logic [15:0] divisor;
  logic [2:0]  fill_count;
  logic        rx_avail;
  logic        rx_done;
  logic        tx_take;
  logic [7:0]  fifo_head;
  logic [7:0]  rx_byte;
  uart_pkg::tx_state_t tx_state_reg, tx_state_next;
  logic        hold_valid_reg, hold_valid_next;

  // receive line conditioning
  logic        sync1_reg, sync2_reg, sync3_reg;
  logic        line_reg, line_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and registers
  assign s_axil_awready = !aw_full_reg && !bvalid_reg;
  assign s_axil_wready  = !w_full_reg && !bvalid_reg;
  assign s_axil_arready = !rvalid_reg;
  assign s_axil_bvalid  = bvalid_reg;
  assign s_axil_bresp   = bresp_reg;
  assign s_axil_rvalid  = rvalid_reg;
  assign s_axil_rresp   = rresp_reg;
  assign s_axil_rdata   = rdata_reg;

  assign divisor  = {div_high_reg, div_low_reg};
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign do_read  = s_axil_arvalid && !rvalid_reg;
  // reading the data register takes the oldest byte
  assign pop      = do_read && (s_axil_araddr == `ADDR_DATA)
                    && (fill_count != 3'h0);
  assign tx_take  = tx_pend_reg && (tx_state_reg == uart_pkg::TX_IDLE);

  always_comb begin
    if (trig_reg == 2'b00) begin
      rx_avail = (fill_count == 3'h4);
    end else begin
      rx_avail = (fill_count >= {1'b0, trig_reg});
    end
  end

  // flag raises the request only when enabled
  // overrun joins the request under the same enable
  assign port_irq = rxie_reg && (rx_avail || overrun_reg);

  always_comb begin
    aw_addr_next  = aw_addr_reg;
    aw_full_next  = aw_full_reg;
    w_data_next   = w_data_reg;
    w_lane_next   = w_lane_reg;
    w_full_next   = w_full_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    div_high_next = div_high_reg;
    div_low_next  = div_low_reg;
    mod_next      = mod_reg;
    range_next    = range_reg;
    trig_next     = trig_reg;
    enable_next   = enable_reg;
    rxie_next     = rxie_reg;
    overrun_next  = overrun_reg;
    tx_pend_next  = tx_pend_reg;
    tx_buf_next   = tx_buf_reg;
    if (s_axil_awvalid && s_axil_awready) begin
      aw_addr_next = s_axil_awaddr;
      aw_full_next = 1'b1;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      w_data_next = s_axil_wdata[7:0];
      w_lane_next = s_axil_wstrb[0];
      w_full_next = 1'b1;
    end
    if (tx_take) begin
      tx_pend_next = 1'b0;
    end
    // overrun cleared by writing one; a new overrun below wins
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `RESP_OKAY;
      unique case (aw_addr_reg)
        `ADDR_DATA: begin
          if (w_lane_reg && enable_reg) begin
            tx_buf_next  = w_data_reg;
            tx_pend_next = 1'b1;
          end
        end
        `ADDR_DIV_HIGH: if (w_lane_reg) div_high_next = w_data_reg;
        `ADDR_DIV_LOW:  if (w_lane_reg) div_low_next = w_data_reg;
        `ADDR_FIFO_MOD: begin
          if (w_lane_reg) begin
            mod_next   = w_data_reg[`FMC_MOD_MSB:`FMC_MOD_LSB];
            range_next = w_data_reg[`FMC_RANGE_BIT];
            trig_next  = w_data_reg[`FMC_TRIG_MSB:`FMC_TRIG_LSB];
          end
        end
        `ADDR_CONTROL: begin
          if (w_lane_reg) begin
            enable_next = w_data_reg[`CTL_ENABLE_BIT];
            rxie_next   = w_data_reg[`CTL_RXIE_BIT];
          end
        end
        `ADDR_STATUS: begin
          if (w_lane_reg && w_data_reg[`STS_OVERRUN_BIT]) begin
            overrun_next = 1'b0;
          end
        end
        `ADDR_FILL_COUNT: ;
        default: bresp_next = `RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axil_bready) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && s_axil_rready) begin
      rvalid_next = 1'b0;
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      unique case (s_axil_araddr)
        `ADDR_DATA:       rdata_next[7:0] = fifo_head;
        `ADDR_DIV_HIGH:   rdata_next[7:0] = div_high_reg;
        `ADDR_DIV_LOW:    rdata_next[7:0] = div_low_reg;
        `ADDR_FIFO_MOD: begin
          rdata_next[`FMC_MOD_MSB:`FMC_MOD_LSB]   = mod_reg;
          rdata_next[`FMC_RANGE_BIT]              = range_reg;
          rdata_next[`FMC_TRIG_MSB:`FMC_TRIG_LSB] = trig_reg;
        end
        `ADDR_FILL_COUNT: rdata_next[2:0] = fill_count;
        `ADDR_CONTROL: begin
          rdata_next[`CTL_ENABLE_BIT] = enable_reg;
          rdata_next[`CTL_RXIE_BIT]   = rxie_reg;
        end
        `ADDR_STATUS: begin
          rdata_next[`STS_RXAVAIL_BIT] = rx_avail;
          rdata_next[`STS_OVERRUN_BIT] = overrun_reg;
          rdata_next[`STS_TXEMPTY_BIT] = !tx_pend_reg;
        end
        default: rresp_next = `RESP_SLVERR;
      endcase
    end
    // sixth byte replacing the held one marks overrun
    if (rx_done && (fill_count == 3'h4) && hold_valid_reg && !pop) begin
      overrun_next = 1'b1;
    end
    // disabled port drops overrun and pending transmit byte
    if (!enable_reg) begin
      overrun_next = 1'b0;
      tx_pend_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg  <= 8'h00;
      aw_full_reg  <= 1'b0;
      w_data_reg   <= 8'h00;
      w_lane_reg   <= 1'b0;
      w_full_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= `RESP_OKAY;
      rdata_reg    <= 32'h0000_0000;
      div_high_reg <= `DIV_BYTE_RESET;
      div_low_reg  <= `DIV_BYTE_RESET;
      mod_reg      <= 3'(`FMC_RESET >> `FMC_MOD_LSB);
      range_reg    <= 1'(`FMC_RESET >> `FMC_RANGE_BIT);
      trig_reg     <= 2'(`FMC_RESET >> `FMC_TRIG_LSB);
      enable_reg   <= 1'b0;
      rxie_reg     <= 1'b0;
      overrun_reg  <= 1'b0;
      tx_pend_reg  <= 1'b0;
      tx_buf_reg   <= 8'h00;
    end else begin
      aw_addr_reg  <= aw_addr_next;
      aw_full_reg  <= aw_full_next;
      w_data_reg   <= w_data_next;
      w_lane_reg   <= w_lane_next;
      w_full_reg   <= w_full_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
      div_high_reg <= div_high_next;
      div_low_reg  <= div_low_next;
      mod_reg      <= mod_next;
      range_reg    <= range_next;
      trig_reg     <= trig_next;
      enable_reg   <= enable_next;
      rxie_reg     <= rxie_next;
      overrun_reg  <= overrun_next;
      tx_pend_reg  <= tx_pend_next;
      tx_buf_reg   <= tx_buf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit timing helpers
  // carry out of the 3-bit sum stretches the bit by one clock
  function automatic logic [16:0] bit_len(input logic [15:0] div,
                                          input logic [3:0]  acc,
                                          input logic [2:0]  md);
    logic [3:0] sum;
    sum = {1'b0, acc[2:0]} + {1'b0, md};
    bit_len = {1'b0, div} + {16'h0000, (sum >= `MOD_CARRY_LIMIT)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive line: three flops, change taken once second and third agree
  always_comb begin
    line_next = line_reg;
    if (sync2_reg == sync3_reg) begin
      line_next = sync3_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      line_reg  <= 1'b1;
    end else begin
      sync1_reg <= serial_in_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      line_reg  <= line_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  uart_pkg::rx_state_t rx_state_reg, rx_state_next;
  logic [16:0] rx_cnt_reg, rx_cnt_next;
  logic [16:0] rx_len_reg, rx_len_next;
  logic [3:0]  rx_acc_reg, rx_acc_next;
  logic [3:0]  rx_bits_reg, rx_bits_next;
  logic [7:0]  rx_shift_reg, rx_shift_next;
  logic [1:0]  votes_reg, votes_next;
  logic [16:0] half, pt0, pt1, pt2;
  logic        bit_end, vote;

  // first two sample points move with range select; the third stays at half plus two
  assign half = {2'b00, divisor[15:1]};
  assign pt0  = range_reg ? half - 17'h00001 : half;
  assign pt1  = range_reg ? half : half + 17'h00001;
  assign pt2  = half + 17'h00002;
  assign bit_end = (rx_cnt_reg + 17'h00001) >= rx_len_reg;
  assign vote = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & line_reg)
              | (votes_reg[1] & line_reg);
  assign rx_done = (rx_state_reg == uart_pkg::RX_STOP) && (rx_cnt_reg == pt2);
  assign rx_byte = rx_shift_reg;

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next   = rx_cnt_reg + 17'h00001;
    rx_len_next   = rx_len_reg;
    rx_acc_next   = rx_acc_reg;
    rx_bits_next  = rx_bits_reg;
    rx_shift_next = rx_shift_reg;
    votes_next    = votes_reg;
    if (rx_cnt_reg == pt0) votes_next[0] = line_reg;
    if (rx_cnt_reg == pt1) votes_next[1] = line_reg;
    unique case (rx_state_reg)
      uart_pkg::RX_IDLE: begin
        rx_cnt_next = 17'h00000;
        if (enable_reg && !line_reg) begin
          // fresh accumulator; start bit takes the first addition
          rx_state_next = uart_pkg::RX_START;
          rx_len_next   = bit_len(divisor, 4'h0, mod_reg);
          rx_acc_next   = {1'b0, mod_reg};
        end
      end
      uart_pkg::RX_START: begin
        if (rx_cnt_reg == pt2 && vote) begin
          rx_state_next = uart_pkg::RX_IDLE;
        end
      end
      uart_pkg::RX_DATA: begin
        if (rx_cnt_reg == pt2) begin
          rx_shift_next = {vote, rx_shift_reg[7:1]};
        end
      end
      uart_pkg::RX_STOP: begin
        // stop bit sampled, hand back to idle for resync
        if (rx_done) begin
          rx_state_next = uart_pkg::RX_IDLE;
        end
      end
    endcase
    // receiver bits follow the same modulation
    if (bit_end && rx_state_reg != uart_pkg::RX_IDLE && !rx_done) begin
      rx_cnt_next = 17'h00000;
      rx_len_next = bit_len(divisor, rx_acc_reg, mod_reg);
      rx_acc_next = rx_acc_reg + {1'b0, mod_reg};
      if (rx_state_reg == uart_pkg::RX_START) begin
        rx_state_next = uart_pkg::RX_DATA;
        rx_bits_next  = 4'h0;
      end else if (rx_state_reg == uart_pkg::RX_DATA) begin
        rx_bits_next = rx_bits_reg + 4'h1;
        if (rx_bits_reg + 4'h1 == `DATA_BITS) begin
          rx_state_next = uart_pkg::RX_STOP;
        end
      end
    end
    if (!enable_reg) begin
      rx_state_next = uart_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= uart_pkg::RX_IDLE;
      rx_cnt_reg   <= 17'h00000;
      rx_len_reg   <= 17'h00000;
      rx_acc_reg   <= 4'h0;
      rx_bits_reg  <= 4'h0;
      rx_shift_reg <= 8'h00;
      votes_reg    <= 2'b11;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg   <= rx_cnt_next;
      rx_len_reg   <= rx_len_next;
      rx_acc_reg   <= rx_acc_next;
      rx_bits_reg  <= rx_bits_next;
      rx_shift_reg <= rx_shift_next;
      votes_reg    <= votes_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive fifo with one overflow holding byte
  logic [7:0] mem_reg [FIFO_DEPTH];
  logic [7:0] mem_next [FIFO_DEPTH];
  logic [1:0] rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
  logic [2:0] count_reg, count_next;
  logic [7:0] hold_reg, hold_next;
  logic [1:0] wr_slot;

  assign fill_count = count_reg;
  assign fifo_head  = mem_reg[rd_ptr_reg];

  always_comb begin
    mem_next        = mem_reg;
    rd_ptr_next     = rd_ptr_reg;
    wr_ptr_next     = wr_ptr_reg;
    count_next      = count_reg;
    hold_next       = hold_reg;
    hold_valid_next = hold_valid_reg;
    wr_slot         = wr_ptr_reg;
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 2'b01;
      count_next  = count_reg - 3'h1;
      // slot freed by a read takes the held byte first
      if (hold_valid_reg) begin
        mem_next[wr_slot] = hold_reg;
        wr_ptr_next       = wr_ptr_reg + 2'b01;
        count_next        = count_reg;
        hold_valid_next   = 1'b0;
        wr_slot           = wr_ptr_reg + 2'b01;
      end
    end
    if (rx_done) begin
      if (count_next != 3'(FIFO_DEPTH)) begin
        mem_next[wr_slot] = rx_byte;
        wr_ptr_next       = wr_slot + 2'b01;
        count_next        = count_next + 3'h1;
      end else begin
        // overflow goes to the holding byte, newest wins
        hold_next       = rx_byte;
        hold_valid_next = 1'b1;
      end
    end
    // count cleared while the port is off
    if (!enable_reg) begin
      rd_ptr_next     = 2'b00;
      wr_ptr_next     = 2'b00;
      count_next      = 3'h0;
      hold_valid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr_reg     <= 2'b00;
      wr_ptr_reg     <= 2'b00;
      count_reg      <= 3'h0;
      hold_reg       <= 8'h00;
      hold_valid_reg <= 1'b0;
    end else begin
      rd_ptr_reg     <= rd_ptr_next;
      wr_ptr_reg     <= wr_ptr_next;
      count_reg      <= count_next;
      hold_reg       <= hold_next;
      hold_valid_reg <= hold_valid_next;
    end
  end

  // storage has no reset; contents are unknown until written
  always_ff @(posedge aclk) begin
    mem_reg <= mem_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: start, eight data, two stop
  logic [16:0] tx_cnt_reg, tx_cnt_next;
  logic [16:0] tx_len_reg, tx_len_next;
  logic [3:0]  tx_acc_reg, tx_acc_next;
  logic [3:0]  tx_bits_reg, tx_bits_next;
  logic [10:0] tx_shift_reg, tx_shift_next;

  assign serial_out_pin = tx_shift_reg[0];

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next   = tx_cnt_reg + 17'h00001;
    tx_len_next   = tx_len_reg;
    tx_acc_next   = tx_acc_reg;
    tx_bits_next  = tx_bits_reg;
    tx_shift_next = tx_shift_reg;
    unique case (tx_state_reg)
      uart_pkg::TX_IDLE: begin
        tx_cnt_next = 17'h00000;
        if (tx_take) begin
          // accumulator restarts with the start bit
          tx_state_next = uart_pkg::TX_SHIFT;
          tx_shift_next = {2'b11, tx_buf_reg, 1'b0};
          tx_len_next   = bit_len(divisor, 4'h0, mod_reg);
          tx_acc_next   = {1'b0, mod_reg};
          tx_bits_next  = 4'h0;
        end
      end
      uart_pkg::TX_SHIFT: begin
        // own timer, period from divisor and modulation
        if ((tx_cnt_reg + 17'h00001) >= tx_len_reg) begin
          tx_cnt_next   = 17'h00000;
          tx_shift_next = {1'b1, tx_shift_reg[10:1]};
          tx_bits_next  = tx_bits_reg + 4'h1;
          // transmit bits carry the same correction
          tx_len_next   = bit_len(divisor, tx_acc_reg, mod_reg);
          tx_acc_next   = tx_acc_reg + {1'b0, mod_reg};
          if (tx_bits_reg + 4'h1 == `TX_FRAME_BITS) begin
            tx_state_next = uart_pkg::TX_IDLE;
          end
        end
      end
    endcase
    if (!enable_reg) begin
      tx_state_next = uart_pkg::TX_IDLE;
      tx_shift_next = 11'h7ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= uart_pkg::TX_IDLE;
      tx_cnt_reg   <= 17'h00000;
      tx_len_reg   <= 17'h00000;
      tx_acc_reg   <= 4'h0;
      tx_bits_reg  <= 4'h0;
      tx_shift_reg <= 11'h7ff;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_len_reg   <= tx_len_next;
      tx_acc_reg   <= tx_acc_next;
      tx_bits_reg  <= tx_bits_next;
      tx_shift_reg <= tx_shift_next;
    end
  end

endmodule

// file: uart_baud_gen_rx_fifo_sva.sv
`timescale 1ns/1ps
module uart_baud_gen_rx_fifo_sva #(parameter int FIFO_DEPTH = 4) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axil_awvalid,
  input wire logic       s_axil_awready,
  input wire logic       s_axil_wvalid,
  input wire logic       s_axil_wready,
  input wire logic       s_axil_bvalid,
  input wire logic       s_axil_bready,
  input wire logic       s_axil_arvalid,
  input wire logic       s_axil_arready,
  input wire logic       s_axil_rvalid,
  input wire logic       s_axil_rready,
  input wire logic [1:0] s_axil_rresp,
  input wire logic       serial_out_pin,
  input wire logic       port_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////
  reset_quiet_a: assert property ($rose(aresetn) |-> !s_axil_bvalid &&
    !s_axil_rvalid && serial_out_pin && !port_irq) else $error("not idle");
  write_answer_a: assert property (s_axil_awvalid && s_axil_awready &&
    s_axil_wvalid && s_axil_wready |-> ##[1:2] s_axil_bvalid)
    else $error("no write answer");
  write_refuse_a: assert property (s_axil_bvalid |->
    !s_axil_awready && !s_axil_wready) else $error("write taken early");
  write_done_a: assert property (s_axil_bvalid && s_axil_bready
    |=> !s_axil_bvalid) else $error("write answer repeated");
  read_answer_a: assert property (s_axil_arvalid && s_axil_arready
    |=> s_axil_rvalid) else $error("no read answer");
  read_refuse_a: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read taken early");
  read_done_a: assert property (s_axil_rvalid && s_axil_rready
    |=> !s_axil_rvalid) else $error("read answer repeated");
  start_len_a: assert property ($fell(serial_out_pin)
    |-> !serial_out_pin [*8]) else $error("start bit short");
  cover property (port_irq);
  cover property (s_axil_rvalid && s_axil_rresp == 2'b10);
  cover property ($fell(serial_out_pin));
endmodule
bind uart_baud_gen_rx_fifo uart_baud_gen_rx_fifo_sva
  #(.FIFO_DEPTH(FIFO_DEPTH)) uart_baud_gen_rx_fifo_sva_inst (.*);

// file: serial_station.sv
`timescale 1ns/1ps
module serial_station (
  input  wire logic aclk,
  output logic      line,
  input  wire logic tx_line
);
  initial line = 1'b1;
  task automatic send(input logic [7:0] b, input int d, input int m);
    logic [10:0] f;
    logic [3:0]  s;
    logic [2:0]  acc;
    f = {2'b11, b, 1'b0};
    acc = 3'h0;
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      s = 4'(acc) + 4'(m[2:0]);
      acc = s[2:0];
      repeat (d + s[3]) @(posedge aclk);
    end
  endtask
  task automatic low_len(output int n);
    n = 0;
    do @(posedge aclk); while (tx_line);
    while (!tx_line) begin
      n++;
      @(posedge aclk);
    end
  endtask
endmodule

// file: uart_baud_gen_rx_fifo_tb.sv
`timescale 1ns/1ps
`include "uart_cfg.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module uart_baud_gen_rx_fifo_tb;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0]  awaddr = 0, araddr = 0, rb;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp, rr;
  logic        awready, wready, bvalid, arready, rvalid, txd, rxd, irq;
  int          fails = 0, check_count = 0, cyc = 0, n;
  always #50 aclk = ~aclk;
  uart_baud_gen_rx_fifo #(.FIFO_DEPTH(4)) uart_baud_gen_rx_fifo_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(1'b1), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(1'b1), .serial_in_pin(rxd), .serial_out_pin(txd),
    .port_irq(irq));
  serial_station serial_station_inst (.aclk(aclk), .line(rxd),
    .tx_line(txd));
  ////////////////////////////////////////////////////////////////////
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a; wdata <= {24'h000000, d}; awvalid <= 1; wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rb = rdata[7:0]; rr = rresp;
    `CHK("register", e, rb)
  endtask
  task automatic rx(input logic [7:0] b);
    serial_station_inst.send(b, 16, 0);
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_regs;
    rchk(`ADDR_DIV_HIGH, 8'h00);
    rchk(`ADDR_FIFO_MOD, 8'h00);
    rchk(`ADDR_FILL_COUNT, 8'h00);
    w(`ADDR_DIV_LOW, 8'h10);
    w(`ADDR_DIV_HIGH, 8'h00);
    rchk(`ADDR_DIV_LOW, 8'h10);
    w(`ADDR_FILL_COUNT, 8'h07);
    rchk(`ADDR_FILL_COUNT, 8'h00);
    rchk(8'h1c, 8'h00);
    `CHK("unmapped", `RESP_SLVERR, rr)
    w(8'h1c, 8'h00);
    `CHK("bad write", `RESP_SLVERR, rr)
    $display("regs done");
  endtask
  task t_rx;
    w(`ADDR_CONTROL, 8'h01);
    w(`ADDR_FIFO_MOD, 8'h02);
    rx(8'ha5);
    rx(8'h3c);
    rchk(`ADDR_FILL_COUNT, 8'h02);
    `CHK("irq off", 1'b0, irq)
    w(`ADDR_CONTROL, 8'h03);
    `CHK("irq on", 1'b1, irq)
    rchk(`ADDR_DATA, 8'ha5);
    `CHK("irq low", 1'b0, irq)
    rchk(`ADDR_DATA, 8'h3c);
    for (int i = 0; i < 6; i++) begin
      rx(8'h10 + i[7:0]);
      if (i == 2) for (int t = 0; t < 4; t++) begin
        w(`ADDR_FIFO_MOD, t[7:0]);
        `CHK("trigger", t != 0, irq)
      end
    end
    w(`ADDR_FIFO_MOD, 8'h00);
    `CHK("trigger four", 1'b1, irq)
    rchk(`ADDR_FILL_COUNT, 8'h04);
    rchk(`ADDR_STATUS, 8'h07);
    `CHK("overrun", 1'b1, rb[1])
    for (int i = 0; i < 4; i++) rchk(`ADDR_DATA, 8'h10 + i[7:0]);
    rchk(`ADDR_FILL_COUNT, 8'h01);
    rchk(`ADDR_DATA, 8'h15);
    $display("rx done");
  endtask
  task t_off;
    rx(8'h77);
    w(`ADDR_CONTROL, 8'h02);
    rchk(`ADDR_FILL_COUNT, 8'h00);
    rchk(`ADDR_STATUS, 8'h04);
    `CHK("flags", 2'b00, rb[1:0])
    `CHK("irq off", 1'b0, irq)
    $display("disable done");
  endtask
  task t_mod;
    w(`ADDR_DIV_LOW, 8'h08);
    w(`ADDR_FIFO_MOD, 8'h3c);
    w(`ADDR_CONTROL, 8'h01);
    fork
      serial_station_inst.low_len(n);
      w(`ADDR_DATA, 8'h00);
    join
    `CHK("low time", 79, n)
    serial_station_inst.send(8'hc3, 8, 7);
    rchk(`ADDR_DATA, 8'hc3);
    $display("modulation done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_rx;
    t_off;
    t_mod;
    test_done;
  end
endmodule
